// >>> rsc_pin_model.sv
// Reset switch with an RC pull-up network on the active-low reset pin.
`timescale 1ns/10ps
`default_nettype none
module rsc_pin_model #(
    parameter int RC_CYCLES = 6
) (
    // Clock and switch control.
    input  wire logic i_clk,
    input  wire logic i_press,
    input  wire logic i_slow,
    // Reset pin.
    output var logic  o_pin_n
);
    int   rc_cnt = 0;
    logic pin_r  = 1'h1;
    // A slow network keeps the pin low for a while after the switch opens.
    always @(posedge i_clk) begin
        if (i_press) begin
            rc_cnt <= i_slow ? RC_CYCLES : 0;
            pin_r  <= 1'h0;
        end else if (rc_cnt > 0) begin
            rc_cnt <= rc_cnt - 1;
        end else begin
            pin_r  <= 1'h1;
        end
    end
    assign o_pin_n = pin_r;
endmodule
`default_nettype wire

// >>> rsc_pkg.sv
// Package with constants, types and register map of the reset source controller.
//
// Overview of operation
// - Six reset causes merge: power-on, pin, undervoltage, illegal key, watchdog normal, watchdog sleep.
// - Power-on presets all port data and direction registers to all ones.
// - Normal operation stays inhibited while the reset pin is low.
// - After pin release wait the start-up delay, about 50 ms, before running.
// - A pin reset while running clears the program counter to zero.
// - Pin key 00000 gives I/O, 10101 gives reset pin, others force reset.
// - An illegal pin key resets after two to three slow oscillator cycles.
// - Undervoltage resets only if it lasts longer than the filter time.
// - Undervoltage detection is disabled during sleep.
// - Watchdog expiry in normal mode is a full reset and sets the expiry flag.
// - Watchdog expiry in sleep clears only program counter, stack pointer and watchdog counter, sets both flags.
// - Watchdog wake-up from sleep waits a settle period of 16 system clocks when i_fast_internal_osc is high, none when it is low.
// - Flags: power-on clears both; pin/undervoltage keep; watchdog normal sets expiry; sleep sets both.
// - Every full reset disables all interrupts.
// - Every reset clears the watchdog counter and restarts it.
// - Every full reset switches the timer/event counter off.
// - Every reset points the stack pointer at the top of the stack.
// - Watchdog key 000000 enables, 101101 disables, others force reset.
// - Pin wake-up waits delay plus settle; other wake-ups wait only settle, and none when i_fast_internal_osc is low.
package rsc_pkg;

    // Register byte addresses.
    localparam logic [7:0] RSC_ADDR_PIN_SEL = 8'h00;
    localparam logic [7:0] RSC_ADDR_WDT_KEY = 8'h04;
    localparam logic [7:0] RSC_ADDR_STATUS  = 8'h08;
    localparam logic [7:0] RSC_ADDR_CTRL    = 8'h0c;

    localparam logic [4:0] RSC_PIN_KEY_IO   = 5'h00;
    localparam logic [4:0] RSC_PIN_KEY_RST  = 5'h15;
    localparam logic [5:0] RSC_WDT_KEY_ON   = 6'h00;
    localparam logic [5:0] RSC_WDT_KEY_OFF  = 6'h2d;
    localparam logic [7:0] RSC_PIN_SEL_RST  = 8'h00;
    localparam logic [7:0] RSC_WDT_KEY_RST  = 8'h00;
    localparam logic [7:0] RSC_PORT_RST     = 8'hff;
    localparam logic [7:0] RSC_PC_RST       = 8'h00;

    // Timing in its own units and derived counts at 50 MHz.
    localparam int RSC_CLK_HZ           = 50000000;
    localparam int RSC_STARTUP_DELAY_MS = 50;
    localparam int RSC_STARTUP_CYCLES   = RSC_CLK_HZ / 1000 * RSC_STARTUP_DELAY_MS;
    localparam int RSC_SETTLE_CYCLES    = 16;
    localparam int RSC_FILTER_US        = 1000;
    localparam int RSC_FILTER_CYCLES    = RSC_CLK_HZ / 1000000 * RSC_FILTER_US;
    localparam int RSC_KEY_SLOW_CYCLES  = 2;
    localparam int RSC_SLOW_DIV         = 4167;

    typedef enum logic [1:0] {
        RSC_RUN    = 2'b00,
        RSC_HOLD   = 2'b01,
        RSC_DELAY  = 2'b10,
        RSC_SETTLE = 2'b11
    } rsc_state_e;

    typedef struct packed {
        logic full_rst;
        logic warm_rst;
        logic clear_flags;
        logic set_expiry;
        logic set_powerdown;
    } rsc_cause_s;

    typedef struct packed {
        logic [7:0] port_data;
        logic [7:0] port_dir;
        logic [7:0] pc;
        logic       sp_top;
        logic       int_off;
        logic       wdt_clear;
        logic       timer_off;
    } rsc_init_s;

endpackage

// >>> rsc_reset_ctrl.sv
// Reset source controller: cause merge, start-up delays, flags and APB registers.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl
    import rsc_pkg::*;
#(
    parameter int STARTUP_CYCLES = RSC_STARTUP_CYCLES,
    parameter int FILTER_CYCLES  = RSC_FILTER_CYCLES,
    parameter int SLOW_DIV       = RSC_SLOW_DIV
) (
    // Clock and power-on reset.
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // Reset sources.
    input  wire logic        i_external_init_pin_n,
    input  wire logic        i_undervoltage_detect,
    input  wire logic        i_watchdog_expiry,
    input  wire logic        i_sleep,
    input  wire logic        i_fast_internal_osc,
    // Reset results.
    output logic             o_core_hold,
    output logic             o_full_rst,
    output logic             o_warm_rst,
    output logic             o_watchdog_enable,
    output logic             o_pin_is_reset,
    output logic             o_watchdog_expiry_flag,
    output logic             o_powerdown_flag,
    output rsc_init_s        o_init
);
    localparam int CW = 32;

    function automatic logic pin_key_bad(input logic [4:0] k);
        pin_key_bad = (k != RSC_PIN_KEY_IO) && (k != RSC_PIN_KEY_RST);
    endfunction

    function automatic logic wdt_key_bad(input logic [5:0] k);
        wdt_key_bad = (k != RSC_WDT_KEY_ON) && (k != RSC_WDT_KEY_OFF);
    endfunction

    logic pin_lvl;
    logic uv_lvl;

    rsc_sync #(.RESET_VAL(1'b1)) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_external_init_pin_n),
        .o_level (pin_lvl)
    );
    rsc_sync #(.RESET_VAL(1'b0)) u_uv_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async (i_undervoltage_detect),
        .o_level (uv_lvl)
    );

    rsc_state_e  st_r;
    rsc_state_e  st_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [CW-1:0] uv_cnt_r;
    logic [CW-1:0] uv_cnt_nxt;
    logic [CW-1:0] div_r;
    logic [CW-1:0] div_nxt;
    logic [1:0]  key_cnt_r;
    logic [1:0]  key_cnt_nxt;
    logic [7:0]  pin_sel_r;
    logic [7:0]  pin_sel_nxt;
    logic [7:0]  wdt_key_r;
    logic [7:0]  wdt_key_nxt;
    logic        expiry_r;
    logic        expiry_nxt;
    logic        pdf_r;
    logic        pdf_nxt;
    logic        por_r;
    logic        por_nxt;
    logic        full_r;
    logic        full_nxt;
    logic        warm_r;
    logic        warm_nxt;
    logic        pin_hold_r;
    logic        pin_hold_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic slow_tick;
    logic pin_rst;
    logic uv_rst;
    logic key_rst;
    logic wdt_norm;
    logic wdt_sleep;
    logic wr;
    logic rd;
    rsc_cause_s cause;

    assign slow_tick = (div_r == CW'(SLOW_DIV - 1));
    assign wr        = i_psel && i_penable && i_pwrite;
    assign rd        = i_psel && i_penable && !i_pwrite;
    // The pin only acts as reset input when selected by its key. The reset it
    // starts returns the key to plain I/O, so a hold bit keeps it until release.
    assign pin_rst   = ((pin_sel_r[4:0] == RSC_PIN_KEY_RST) || pin_hold_r) && !pin_lvl;
    assign uv_rst    = (uv_cnt_r >= CW'(FILTER_CYCLES));
    assign key_rst   = (key_cnt_r == 2'(RSC_KEY_SLOW_CYCLES)) && slow_tick;
    assign wdt_norm  = i_watchdog_expiry && !i_sleep;
    assign wdt_sleep = i_watchdog_expiry && i_sleep;

    // Cause priority decides flags and which reset kind applies.
    always_comb begin
        cause = '0;
        if (por_r) begin
            cause.full_rst    = 1'b1;
            cause.clear_flags = 1'b1;
        end else if (uv_rst || pin_rst || key_rst) begin
            cause.full_rst = 1'b1;
        end else if (wdt_norm) begin
            cause.full_rst   = 1'b1;
            cause.set_expiry = 1'b1;
        end else if (wdt_sleep) begin
            cause.warm_rst      = 1'b1;
            cause.set_expiry    = 1'b1;
            cause.set_powerdown = 1'b1;
        end
    end

    always_comb begin
        div_nxt     = slow_tick ? '0 : div_r + CW'(1);
        uv_cnt_nxt  = uv_cnt_r;
        key_cnt_nxt = key_cnt_r;
        pin_hold_nxt = pin_rst;
        if (uv_lvl && !i_sleep) begin
            if (!uv_rst) begin
                uv_cnt_nxt = uv_cnt_r + CW'(1);
            end
        end else begin
            uv_cnt_nxt = '0;
        end
        if (pin_key_bad(pin_sel_r[4:0]) || wdt_key_bad(wdt_key_r[5:0])) begin
            if (slow_tick && key_cnt_r != 2'(RSC_KEY_SLOW_CYCLES)) begin
                key_cnt_nxt = key_cnt_r + 2'd1;
            end
        end else begin
            key_cnt_nxt = '0;
        end
    end

    // Sequencer: hold during a full reset, then delay and settle; a warm reset only settles, and only when i_fast_internal_osc is high.
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        full_nxt = cause.full_rst;
        warm_nxt = cause.warm_rst;
        por_nxt  = 1'b0;
        case (st_r)
            RSC_RUN: begin
                if (cause.full_rst) begin
                    st_nxt = RSC_HOLD;
                end else if (cause.warm_rst) begin
                    st_nxt  = i_fast_internal_osc ? RSC_SETTLE : RSC_RUN;
                    cnt_nxt = '0;
                end
            end
            RSC_HOLD: begin
                full_nxt = 1'b1;
                if (!cause.full_rst) begin
                    st_nxt  = RSC_DELAY;
                    cnt_nxt = '0;
                end
            end
            RSC_DELAY: begin
                full_nxt = 1'b1;
                if (cause.full_rst) begin
                    st_nxt = RSC_HOLD;
                end else if (cnt_r >= CW'(STARTUP_CYCLES - 1)) begin
                    st_nxt  = RSC_SETTLE;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            RSC_SETTLE: begin
                if (cause.full_rst) begin
                    st_nxt = RSC_HOLD;
                end else if (cnt_r >= CW'(RSC_SETTLE_CYCLES - 1)) begin
                    st_nxt = RSC_RUN;
                end else begin
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            default: begin
                st_nxt = RSC_HOLD;
            end
        endcase
    end

    // Registers and flags; a full reset restores key registers.
    always_comb begin
        pin_sel_nxt = pin_sel_r;
        wdt_key_nxt = wdt_key_r;
        expiry_nxt  = expiry_r;
        pdf_nxt     = pdf_r;
        rdata_nxt   = rdata_r;
        if (wr && i_paddr == RSC_ADDR_PIN_SEL) begin
            pin_sel_nxt = {3'b000, i_pwdata[4:0]};
        end
        if (wr && i_paddr == RSC_ADDR_WDT_KEY) begin
            wdt_key_nxt = {2'b00, i_pwdata[5:0]};
        end
        if (wr && i_paddr == RSC_ADDR_STATUS) begin
            expiry_nxt = expiry_r & i_pwdata[0];
            pdf_nxt    = pdf_r & i_pwdata[1];
        end
        if (cause.full_rst) begin
            pin_sel_nxt = RSC_PIN_SEL_RST;
            wdt_key_nxt = RSC_WDT_KEY_RST;
        end
        if (cause.clear_flags) begin
            expiry_nxt = 1'b0;
            pdf_nxt    = 1'b0;
        end
        if (cause.set_expiry) begin
            expiry_nxt = 1'b1;
        end
        if (cause.set_powerdown) begin
            pdf_nxt = 1'b1;
        end
        if (rd) begin
            case (i_paddr)
                RSC_ADDR_PIN_SEL: rdata_nxt = {24'h000000, pin_sel_r};
                RSC_ADDR_WDT_KEY: rdata_nxt = {24'h000000, wdt_key_r};
                RSC_ADDR_STATUS:  rdata_nxt = {30'h0, pdf_r, expiry_r};
                RSC_ADDR_CTRL:    rdata_nxt = {28'h0000000, full_r, warm_r, st_r};
                default:          rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r      <= RSC_HOLD;
            cnt_r     <= '0;
            uv_cnt_r  <= '0;
            div_r     <= '0;
            key_cnt_r <= '0;
            pin_sel_r <= RSC_PIN_SEL_RST;
            wdt_key_r <= RSC_WDT_KEY_RST;
            expiry_r  <= 1'b0;
            pdf_r     <= 1'b0;
            por_r     <= 1'b1;
            full_r    <= 1'b1;
            warm_r    <= 1'b0;
            pin_hold_r <= 1'b0;
            rdata_r   <= '0;
        end else begin
            st_r      <= st_nxt;
            cnt_r     <= cnt_nxt;
            uv_cnt_r  <= uv_cnt_nxt;
            div_r     <= div_nxt;
            key_cnt_r <= key_cnt_nxt;
            pin_sel_r <= pin_sel_nxt;
            wdt_key_r <= wdt_key_nxt;
            expiry_r  <= expiry_nxt;
            pdf_r     <= pdf_nxt;
            por_r     <= por_nxt;
            full_r    <= full_nxt;
            warm_r    <= warm_nxt;
            pin_hold_r <= pin_hold_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // Register read data is a registered value; pready waits one cycle for it.
    logic rd_done_r;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_done_r <= 1'b0;
        end else begin
            rd_done_r <= i_psel && i_penable && !rd_done_r;
        end
    end

    assign o_pready  = i_psel && i_penable && rd_done_r;
    assign o_prdata  = rdata_r;
    assign o_pslverr = 1'b0;

    assign o_core_hold            = (st_r != RSC_RUN);
    assign o_full_rst             = full_r;
    assign o_warm_rst             = warm_r;
    assign o_watchdog_enable      = (wdt_key_r[5:0] == RSC_WDT_KEY_ON);
    assign o_pin_is_reset         = (pin_sel_r[4:0] == RSC_PIN_KEY_RST);
    assign o_watchdog_expiry_flag = expiry_r;
    assign o_powerdown_flag       = pdf_r;
    // Init values applied by the core while a reset pulse is high.
    assign o_init.port_data = RSC_PORT_RST;
    assign o_init.port_dir  = RSC_PORT_RST;
    assign o_init.pc        = RSC_PC_RST;
    assign o_init.sp_top    = full_r | warm_r;
    assign o_init.int_off   = full_r;
    assign o_init.wdt_clear = full_r | warm_r;
    assign o_init.timer_off = full_r;
endmodule
`default_nettype wire

// >>> rsc_reset_ctrl_monitor.sv
// Port-level checker of the reset source controller, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl_monitor
    import rsc_pkg::*;
#(
    parameter int SLOW_DIV = RSC_SLOW_DIV
) (
    // Clock, reset and register bus.
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    // Reset sources and results.
    input wire logic        i_external_init_pin_n,
    input wire logic        i_watchdog_expiry,
    input wire logic        i_sleep,
    input wire logic        o_core_hold,
    input wire logic        o_full_rst,
    input wire logic        o_warm_rst,
    input wire logic        o_watchdog_enable,
    input wire logic        o_pin_is_reset,
    input wire logic        o_watchdog_expiry_flag,
    input wire logic        o_powerdown_flag,
    input wire rsc_init_s   o_init
);
    localparam int KEY_MAX = (4 * SLOW_DIV + 4 > 1000) ? 1000 : 4 * SLOW_DIV + 4;
    logic wr_first;
    logic bad_key;
    assign wr_first = i_psel && i_penable && !o_pready && i_pwrite;
    assign bad_key  = (i_paddr == 8'h00 && i_pwdata[4:0] != 5'h00 && i_pwdata[4:0] != 5'h15) ||
                      (i_paddr == 8'h04 && i_pwdata[5:0] != 6'h00 && i_pwdata[5:0] != 6'h2d);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_one_wait: assert property ($rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
        else $error("bus answer not after one wait state");
    a_port_init: assert property (o_init.port_data == 8'hff && o_init.port_dir == 8'hff && o_init.pc == 8'h00)
        else $error("reset values of ports or program counter wrong");
    a_full_effects: assert property (o_full_rst |-> o_init.int_off && o_init.timer_off && o_init.sp_top && o_init.wdt_clear)
        else $error("full reset effects missing");
    a_warm_only: assert property (o_warm_rst && !o_full_rst |-> o_init.sp_top && o_init.wdt_clear && !o_init.timer_off)
        else $error("warm reset effects wrong");
    a_full_holds: assert property (o_full_rst |=> o_core_hold)
        else $error("core runs after full reset");
    a_pin_key: assert property (wr_first && i_paddr == 8'h00 |=> o_pin_is_reset == ($past(i_pwdata[4:0]) == 5'h15))
        else $error("pin key decode wrong");
    a_wdt_key: assert property (wr_first && i_paddr == 8'h04 |=> o_watchdog_enable == ($past(i_pwdata[5:0]) == 6'h00))
        else $error("watchdog key decode wrong");
    a_bad_key: assert property (wr_first && bad_key |-> !o_full_rst [*4] ##[1:KEY_MAX] o_full_rst)
        else $error("illegal key reset timing wrong");
    a_wdt_normal: assert property (i_watchdog_expiry && !i_sleep && !o_core_hold |-> ##[1:2] (o_full_rst && o_watchdog_expiry_flag))
        else $error("watchdog expiry in run gave no full reset");
    a_wdt_sleep: assert property (i_watchdog_expiry && i_sleep && !o_core_hold |-> ##[1:2] (o_warm_rst && !o_full_rst))
        else $error("watchdog expiry in sleep gave no warm reset");
    a_pin_inhibit: assert property ((!i_external_init_pin_n && o_pin_is_reset) [*3] |-> ##[1:6] o_core_hold)
        else $error("pin low does not hold the core");
    a_por_flags: assert property ($fell(i_reset) |-> (!o_watchdog_expiry_flag && !o_powerdown_flag) [*3])
        else $error("flags not cleared by power-on");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_monitor #(.SLOW_DIV(SLOW_DIV)) i_rsc_reset_ctrl_monitor (.*);
`default_nettype wire

// >>> rsc_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/10ps
`default_nettype none
module rsc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Asynchronous input and filtered level.
    input  wire logic i_async,
    output logic      o_level
);
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic       lvl_r;
    logic       lvl_nxt;

    always_comb begin
        sh_nxt  = {sh_r[1:0], i_async};
        lvl_nxt = (sh_r[2] == sh_r[1]) ? sh_r[2] : lvl_r;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sh_r  <= {3{RESET_VAL}};
            lvl_r <= RESET_VAL;
        end else begin
            sh_r  <= sh_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the reset source controller.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rsc_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] r;
        logic        p;
        logic        e;
    } rsc_row_s;
    localparam int STARTUP = 50;
    logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic        uv = 1'h0, wdt = 1'h0, slp = 1'h0, press = 1'h0, slow = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic        pready, pslverr, pin_n, hold, full, warm, wen, pin_rst;
    rsc_init_s   init;
    int          error_cnt = 0;
    int          check_count = 0;
    int          n;
    integer      fc, wc, hc;
    rsc_row_s    rows [7] = '{
        '{8'h00, 32'h15, 32'h15, 1'h1, 1'h1},
        '{8'h04, 32'h2d, 32'h2d, 1'h1, 1'h0},
        '{8'h04, 32'h00, 32'h00, 1'h1, 1'h1},
        '{8'h00, 32'h00, 32'h00, 1'h0, 1'h1},
        '{8'h10, 32'hffff_ffff, 32'h00, 1'h0, 1'h1},
        '{8'h0c, 32'hff, 32'h00, 1'h0, 1'h1},
        '{8'h08, 32'h00, 32'h00, 1'h0, 1'h1}
    };

    rsc_pin_model i_rsc_pin_model (.i_clk(clk), .i_press(press), .i_slow(slow), .o_pin_n(pin_n));
    rsc_reset_ctrl #(.STARTUP_CYCLES(STARTUP), .FILTER_CYCLES(10), .SLOW_DIV(4)) i_rsc_reset_ctrl (
        .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_external_init_pin_n(pin_n), .i_undervoltage_detect(uv), .i_watchdog_expiry(wdt),
        .i_sleep(slp), .i_fast_internal_osc(1'h1), .o_core_hold(hold), .o_full_rst(full),
        .o_warm_rst(warm), .o_watchdog_enable(wen), .o_pin_is_reset(pin_rst),
        .o_watchdog_expiry_flag(), .o_powerdown_flag(), .o_init(init));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        q = prdata;
        psel <= 1'h0;
        pen <= 1'h0;
        chk(k < 20, 1, "bus answer");
    endtask

    task automatic watch(input int c);
        fc = 0;
        wc = 0;
        hc = 0;
        repeat (c) begin
            @(posedge clk);
            fc += full;
            wc += warm;
            hc += hold;
        end
    endtask

    // Lets a just-raised cause reach the state register before polling.
    task automatic wait_run(output int c);
        repeat (4) @(posedge clk);
        c = 4;
        while (hold !== 1'h0 && c < 500) begin
            @(posedge clk);
            c++;
        end
        chk(c < 500, 1, "core release");
    endtask

    task automatic pulse_wdt;
        @(posedge clk);
        wdt <= 1'h1;
        @(posedge clk);
        wdt <= 1'h0;
    endtask

    initial begin
        forever #10 clk = ~clk;
    end

    initial begin
        #500us;
        error_cnt++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wait_run(n);
        chk(n >= STARTUP + 16 && n <= STARTUP + 24, 1, "power-on delay");
        chk(init.port_dir & init.port_data, 8'hff, "port preset");
        apb(0, 8'h08, 0);
        chk(q, 0, "power-on flags");
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            apb(0, rows[i].a, 0);
            chk(q, rows[i].r, "read back");
            chk({pin_rst, wen, pslverr}, {rows[i].p, rows[i].e, 1'h0}, "key decode");
        end
        pulse_wdt();
        wait_run(n);
        chk(n >= STARTUP, 1, "watchdog reset length");
        apb(0, 8'h08, 0);
        chk(q, 32'h1, "watchdog flags");
        slp <= 1'h1;
        pulse_wdt();
        watch(40);
        chk(wc == 1 && fc == 0, 1, "warm reset only");
        chk(hc >= 16 && hc <= 18, 1, "settle period");
        apb(0, 8'h08, 0);
        chk(q, 32'h3, "sleep flags");
        uv <= 1'h1;
        watch(30);
        uv <= 1'h0;
        chk(fc, 0, "undervoltage in sleep");
        watch(10);
        slp <= 1'h0;
        uv <= 1'h1;
        watch(8);
        uv <= 1'h0;
        watch(30);
        chk(fc, 0, "short undervoltage");
        uv <= 1'h1;
        watch(30);
        uv <= 1'h0;
        chk(fc > 0, 1, "long undervoltage");
        wait_run(n);
        apb(0, 8'h08, 0);
        chk(q, 32'h3, "flags kept");
        apb(1, 8'h00, 32'h15);
        press <= 1'h1;
        slow <= 1'h1;
        watch(20);
        press <= 1'h0;
        chk(fc > 0, 1, "pin reset");
        wait_run(n);
        chk(n >= STARTUP + 16, 1, "pin release delay");
        chk(init.pc, 0, "restart address");
        apb(0, 8'h00, 0);
        chk(q, 0, "pin key after reset");
        press <= 1'h1;
        watch(20);
        press <= 1'h0;
        chk(fc, 0, "pin as plain io");
        for (int i = 0; i < 2; i++) begin
            apb(1, i ? 8'h04 : 8'h00, i ? 32'h01 : 32'h07);
            watch(25);
            chk(fc > 0, 1, "illegal key reset");
            wait_run(n);
        end
        pulse_wdt();
        repeat (5) @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wait_run(n);
        apb(0, 8'h08, 0);
        chk(q, 0, "power-on beats watchdog");
        complete_run();
    end
endmodule
`default_nettype wire
